// ===== rtl/msaf_monitor.sv
`timescale 1ns/100ps
module msaf_monitor (
    // clock and reset
    input  wire logic                                   clk_sys_i,
    input  wire logic                                   reset_i,
    // byte register port of the serial interface
    input  wire logic [7:0]                             reg_addr_i,
    input  wire logic                                   reg_wr_i,
    input  wire logic [7:0]                             reg_wdata_i,
    input  wire logic                                   reg_rd_i,
    output logic      [7:0]                             reg_rdata_o,
    // vendor access unlocked
    input  wire logic                                   vendor_mode_i,
    // shared converter
    output msaf_pkg::msaf_conv_req_s                    conv_req_o,
    input  wire logic                                   conv_done_i,
    input  wire logic [msaf_pkg::RES_BITS-1:0]          conv_result_i,
    // limits per channel, indexed by channel code
    input  msaf_pkg::msaf_limits_s [msaf_pkg::CHAN_COUNT-1:0] limits_i,
    // transmit-off pin
    input  wire logic                                   transmit_off_input_i,
    // results and status
    output logic [msaf_pkg::CHAN_COUNT-1:0][msaf_pkg::RES_BITS-1:0] results_o,
    output logic                                        scan_done_o,
    output logic                                        irq_o,
    output logic                                        transmit_fault_out_o
);

    // keep only the bits a channel really converts
    function automatic logic [msaf_pkg::RES_BITS-1:0] width_mask(input msaf_pkg::msaf_chan_e ch);
        logic [msaf_pkg::RES_BITS-1:0] m;
        m = '0;
        case (ch)
            msaf_pkg::CH_TEMP: m = 12'h1ff;
            msaf_pkg::CH_RX:   m = 12'hfff;
            default:           m = 12'h0ff;
        endcase
        return m;
    endfunction

    // flag pair of a channel: temp 4, voltage 3, bias 2, tx power 1, rx 0
    function automatic int unsigned flag_pair(input msaf_pkg::msaf_chan_e ch);
        int unsigned p;
        p = 0;
        case (ch)
            msaf_pkg::CH_TEMP: p = 4;
            msaf_pkg::CH_AUX:  p = 3;
            msaf_pkg::CH_BIAS: p = 2;
            msaf_pkg::CH_MPD:  p = 1;
            default:           p = 0;
        endcase
        return p;
    endfunction

    // sequencer state and the stored result of every channel
    msaf_pkg::msaf_seq_e   state_ff,   nxt_state;
    msaf_pkg::msaf_chan_e  chan_ff,    nxt_chan;
    msaf_pkg::msaf_aux_e   aux_ff,     nxt_aux;
    logic                  start_ff,   nxt_start;
    logic                  scan_ff,    nxt_scan;
    logic [msaf_pkg::CHAN_COUNT-1:0][msaf_pkg::RES_BITS-1:0] res_ff, nxt_res;

    // decode of the result now arriving from the converter
    logic [msaf_pkg::RES_BITS-1:0] cur_res;
    logic [1:0]                    alarm_viol;
    logic [1:0]                    warn_viol;
    logic                          update;
    int unsigned                   pair;

    // configuration bytes, mask bytes and registered read data
    logic [7:0] cfg0_ff,    nxt_cfg0;
    logic [7:0] cfg4_ff,    nxt_cfg4;
    logic [7:0] amask_a_ff, nxt_amask_a;
    logic [7:0] amask_b_ff, nxt_amask_b;
    logic [7:0] wmask_a_ff, nxt_wmask_a;
    logic [7:0] wmask_b_ff, nxt_wmask_b;
    logic [7:0] rdata_ff,   nxt_rdata;

    // flags, one hi/lo pair per channel, and the outputs they drive
    logic [msaf_pkg::FLAG_BITS-1:0] alarm_ff, nxt_alarm;
    logic [msaf_pkg::FLAG_BITS-1:0] warn_ff,  nxt_warn;
    logic [msaf_pkg::FLAG_BITS-1:0] alarm_mask;
    logic [msaf_pkg::FLAG_BITS-1:0] warn_mask;
    logic                           irq_ff,   nxt_irq;
    logic                           fault_ff, nxt_fault;
    logic                           alarm_any;
    logic                           warn_any;

    // transmit-off pin stages; the second and third stages feed the toggle detect
    logic tx_meta_ff;
    logic tx_sync_ff;
    logic tx_prev_ff;
    logic tx_toggle;

    // violation of the result now arriving
    always_comb begin
        cur_res    = conv_result_i & width_mask(chan_ff);
        pair       = flag_pair(chan_ff);
        update     = (state_ff == msaf_pkg::SEQ_WAIT) && conv_done_i;
        alarm_viol = {cur_res > limits_i[chan_ff].alarm_hi, cur_res < limits_i[chan_ff].alarm_lo};
        warn_viol  = {cur_res > limits_i[chan_ff].warn_hi, cur_res < limits_i[chan_ff].warn_lo};
    end

    // scan sequencer over the shared converter
    always_comb begin
        nxt_state = state_ff;
        nxt_chan  = chan_ff;
        nxt_start = 1'b0;
        nxt_scan  = 1'b0;
        nxt_res   = res_ff;
        nxt_aux   = msaf_pkg::AUX_SUPPLY;
        if (vendor_mode_i && (cfg0_ff[msaf_pkg::AUX_SEL_LSB +: 3] != 3'h7)) begin
            nxt_aux = msaf_pkg::msaf_aux_e'(cfg0_ff[msaf_pkg::AUX_SEL_LSB +: 3]);
        end
        case (state_ff)
            msaf_pkg::SEQ_START: begin
                nxt_start = 1'b1;
                nxt_state = msaf_pkg::SEQ_WAIT;
            end
            msaf_pkg::SEQ_WAIT: begin
                if (conv_done_i) begin
                    nxt_res[chan_ff] = cur_res;
                    nxt_state        = msaf_pkg::SEQ_START;
                    if (chan_ff == msaf_pkg::CH_RX) begin
                        nxt_chan = msaf_pkg::CH_TEMP;
                        nxt_scan = 1'b1;
                    end else begin
                        nxt_chan = msaf_pkg::msaf_chan_e'(chan_ff + 3'h1);
                    end
                end
            end
            default: begin
                nxt_state = msaf_pkg::SEQ_START;
            end
        endcase
    end

    // sequencer registers; reset restarts the scan at temperature
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_ff <= msaf_pkg::SEQ_START;
            chan_ff  <= msaf_pkg::CH_TEMP;
            aux_ff   <= msaf_pkg::AUX_SUPPLY;
            start_ff <= 1'b0;
            scan_ff  <= 1'b0;
            res_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            chan_ff  <= nxt_chan;
            aux_ff   <= nxt_aux;
            start_ff <= nxt_start;
            scan_ff  <= nxt_scan;
            res_ff   <= nxt_res;
        end
    end

    // transmit-off pin synchroniser and toggle detect
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tx_meta_ff <= 1'b0;
            tx_sync_ff <= 1'b0;
            tx_prev_ff <= 1'b0;
        end else begin
            tx_meta_ff <= transmit_off_input_i;
            tx_sync_ff <= tx_meta_ff;
            tx_prev_ff <= tx_sync_ff;
        end
    end

    assign tx_toggle = tx_sync_ff ^ tx_prev_ff;

    // register writes and read data
    always_comb begin
        nxt_cfg0    = cfg0_ff;
        nxt_cfg4    = cfg4_ff;
        nxt_amask_a = amask_a_ff;
        nxt_amask_b = amask_b_ff;
        nxt_wmask_a = wmask_a_ff;
        nxt_wmask_b = wmask_b_ff;
        nxt_rdata   = rdata_ff;
        if (reg_wr_i) begin
            case (reg_addr_i)
                msaf_pkg::ADDR_CFG_ZERO:     nxt_cfg0    = reg_wdata_i;
                msaf_pkg::ADDR_CFG_FOUR:     nxt_cfg4    = reg_wdata_i;
                msaf_pkg::ADDR_ALARM_MASK_A: nxt_amask_a = reg_wdata_i;
                msaf_pkg::ADDR_ALARM_MASK_B: nxt_amask_b = reg_wdata_i & msaf_pkg::MASK_B_USED;
                msaf_pkg::ADDR_WARN_MASK_A:  nxt_wmask_a = reg_wdata_i;
                msaf_pkg::ADDR_WARN_MASK_B:  nxt_wmask_b = reg_wdata_i & msaf_pkg::MASK_B_USED;
                default:                     nxt_cfg0    = cfg0_ff;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                msaf_pkg::ADDR_CFG_ZERO:     nxt_rdata = cfg0_ff;
                msaf_pkg::ADDR_CFG_FOUR:     nxt_rdata = cfg4_ff;
                msaf_pkg::ADDR_ALARM_MASK_A: nxt_rdata = amask_a_ff;
                msaf_pkg::ADDR_ALARM_MASK_B: nxt_rdata = amask_b_ff;
                msaf_pkg::ADDR_WARN_MASK_A:  nxt_rdata = wmask_a_ff;
                msaf_pkg::ADDR_WARN_MASK_B:  nxt_rdata = wmask_b_ff;
                msaf_pkg::ADDR_ALARM_STAT_A: nxt_rdata = alarm_ff[9:2];
                msaf_pkg::ADDR_ALARM_STAT_B: nxt_rdata = {alarm_ff[1:0], 6'h00};
                msaf_pkg::ADDR_WARN_STAT_A:  nxt_rdata = warn_ff[9:2];
                msaf_pkg::ADDR_WARN_STAT_B:  nxt_rdata = {warn_ff[1:0], 6'h00};
                default:                     nxt_rdata = 8'h00;
            endcase
        end
    end

    // configuration and mask registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cfg0_ff    <= msaf_pkg::CFG_RST;
            cfg4_ff    <= msaf_pkg::CFG_RST;
            amask_a_ff <= msaf_pkg::MASK_A_RST;
            amask_b_ff <= msaf_pkg::MASK_B_RST;
            wmask_a_ff <= msaf_pkg::MASK_A_RST;
            wmask_b_ff <= msaf_pkg::MASK_B_RST;
            rdata_ff   <= 8'h00;
        end else begin
            cfg0_ff    <= nxt_cfg0;
            cfg4_ff    <= nxt_cfg4;
            amask_a_ff <= nxt_amask_a;
            amask_b_ff <= nxt_amask_b;
            wmask_a_ff <= nxt_wmask_a;
            wmask_b_ff <= nxt_wmask_b;
            rdata_ff   <= nxt_rdata;
        end
    end

    // alarm and warning flags: clear first, then a new violation wins
    always_comb begin
        nxt_alarm = alarm_ff;
        nxt_warn  = warn_ff;
        if (tx_toggle) begin
            nxt_alarm = '0;
            nxt_warn  = '0;
        end
        if (reg_rd_i) begin
            if (reg_addr_i == msaf_pkg::ADDR_ALARM_STAT_A) begin
                nxt_alarm[9:2] = 8'h00;
            end
            if (reg_addr_i == msaf_pkg::ADDR_ALARM_STAT_B) begin
                nxt_alarm[1:0] = 2'h0;
            end
            if (reg_addr_i == msaf_pkg::ADDR_WARN_STAT_A) begin
                nxt_warn[9:2] = 8'h00;
            end
            if (reg_addr_i == msaf_pkg::ADDR_WARN_STAT_B) begin
                nxt_warn[1:0] = 2'h0;
            end
        end
        if (update) begin
            if (cfg4_ff[msaf_pkg::CFG4_ALARM_FOLLOW]) begin
                nxt_alarm[2*pair +: 2] = alarm_viol;
            end else begin
                nxt_alarm[2*pair +: 2] = nxt_alarm[2*pair +: 2] | alarm_viol;
            end
            if (cfg4_ff[msaf_pkg::CFG4_WARN_FOLLOW]) begin
                nxt_warn[2*pair +: 2] = warn_viol;
            end else begin
                nxt_warn[2*pair +: 2] = nxt_warn[2*pair +: 2] | warn_viol;
            end
        end
    end

    // masked sources onto interrupt and transmit fault
    always_comb begin
        alarm_mask = {amask_a_ff, amask_b_ff[7:6]};
        warn_mask  = {wmask_a_ff, wmask_b_ff[7:6]};
        alarm_any  = |(alarm_ff & ~alarm_mask);
        warn_any   = |(warn_ff & ~warn_mask);
        nxt_irq    = alarm_any | warn_any;
        nxt_fault  = (cfg4_ff[msaf_pkg::CFG4_ALARM_FAULT] & alarm_any)
                   | (cfg4_ff[msaf_pkg::CFG4_WARN_FAULT] & warn_any);
    end

    // flag registers; outputs lag the flags by one cycle
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            alarm_ff <= '0;
            warn_ff  <= '0;
            irq_ff   <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            alarm_ff <= nxt_alarm;
            warn_ff  <= nxt_warn;
            irq_ff   <= nxt_irq;
            fault_ff <= nxt_fault;
        end
    end

    // outputs
    assign conv_req_o.start     = start_ff;
    assign conv_req_o.channel   = chan_ff;
    assign conv_req_o.aux_sel   = aux_ff;
    assign results_o            = res_ff;
    assign scan_done_o          = scan_ff;
    assign reg_rdata_o          = rdata_ff;
    assign irq_o                = irq_ff;
    assign transmit_fault_out_o = fault_ff;

endmodule // msaf_monitor

// ===== rtl/msaf_pkg.sv
// Functional notes
// - The five analog parameters are converted one after another in a fixed repeating order through one shared converter.
// - Every result register is refreshed once in each full pass of the scan.
// - In vendor mode the supply channel may be pointed at another internal node by the auxiliary select field of vendor configuration zero.
// - The auxiliary select codes 000 to 110 pick supply, analog supply, bias, modulation, power-loop DAC, modulation DAC and fault-threshold DAC.
// - Temperature results are 9 bits, auxiliary, photodiode and bias results 8 bits, receive power 12 bits.
// - A limit violation sets its alarm or warning flag and raises the interrupt unless that source is masked.
// - A mask bit at 1 keeps its source off the interrupt while its flag may still set.
// - Alarm mask byte a maps temperature, voltage, bias and transmit power high and low; byte b bits 7 and 6 map receive power high and low.
// - Warning mask bytes a and b use the alarm layout for the warning sources.
// - All mask bits reset to 0 except both receive-power-low masks, which reset to 1.
// - Alarms drive the transmit fault output only when vendor configuration four bit 6 is 1.
// - Warnings drive the transmit fault output only when vendor configuration four bit 7 is 1.
// - Sources feeding the transmit fault output are masked by the same per-source mask bits.
// - Flags latch by default until their status byte is read or the transmit-off input toggles.
// - With vendor configuration four bit 5 at 1 warning flags follow the live condition and still clear on read or toggle.
// - With vendor configuration four bit 4 at 1 alarm flags follow the live condition and still clear on read or toggle.
package msaf_pkg;

    localparam int unsigned CHAN_COUNT = 5;
    localparam int unsigned RES_BITS   = 12;
    localparam int unsigned FLAG_BITS  = 10;

    // result widths per channel
    localparam int unsigned TEMP_BITS = 9;
    localparam int unsigned MID_BITS  = 8;
    localparam int unsigned RX_BITS   = 12;

    // register offsets
    localparam logic [7:0] ADDR_CFG_ZERO     = 8'h09;
    localparam logic [7:0] ADDR_CFG_FOUR     = 8'h19;
    localparam logic [7:0] ADDR_ALARM_STAT_A = 8'h70;
    localparam logic [7:0] ADDR_ALARM_STAT_B = 8'h71;
    localparam logic [7:0] ADDR_WARN_STAT_A  = 8'h74;
    localparam logic [7:0] ADDR_WARN_STAT_B  = 8'h75;
    localparam logic [7:0] ADDR_ALARM_MASK_A = 8'hf8;
    localparam logic [7:0] ADDR_ALARM_MASK_B = 8'hf9;
    localparam logic [7:0] ADDR_WARN_MASK_A  = 8'hfa;
    localparam logic [7:0] ADDR_WARN_MASK_B  = 8'hfb;

    // field positions
    localparam int unsigned AUX_SEL_LSB       = 0;
    localparam int unsigned CFG4_ALARM_FOLLOW = 4;
    localparam int unsigned CFG4_WARN_FOLLOW  = 5;
    localparam int unsigned CFG4_ALARM_FAULT  = 6;
    localparam int unsigned CFG4_WARN_FAULT   = 7;
    localparam logic [7:0]  MASK_B_USED       = 8'hc0;

    // values after reset
    localparam logic [7:0] MASK_A_RST = 8'h00;
    localparam logic [7:0] MASK_B_RST = 8'h40;
    localparam logic [7:0] CFG_RST    = 8'h00;

    // scan order
    typedef enum logic [2:0] {
        CH_TEMP = 3'h0,
        CH_AUX  = 3'h1,
        CH_MPD  = 3'h2,
        CH_BIAS = 3'h3,
        CH_RX   = 3'h4
    } msaf_chan_e;

    // auxiliary channel sources
    typedef enum logic [2:0] {
        AUX_SUPPLY   = 3'h0,
        AUX_ANALOG   = 3'h1,
        AUX_BIAS     = 3'h2,
        AUX_MOD      = 3'h3,
        AUX_PWR_DAC  = 3'h4,
        AUX_MOD_DAC  = 3'h5,
        AUX_FLT_DAC  = 3'h6
    } msaf_aux_e;

    typedef enum logic [0:0] {
        SEQ_START = 1'b0,
        SEQ_WAIT  = 1'b1
    } msaf_seq_e;

    // limits of one channel
    typedef struct packed {
        logic [RES_BITS-1:0] alarm_hi;
        logic [RES_BITS-1:0] alarm_lo;
        logic [RES_BITS-1:0] warn_hi;
        logic [RES_BITS-1:0] warn_lo;
    } msaf_limits_s;

    // request to the shared converter
    typedef struct packed {
        logic       start;
        msaf_chan_e channel;
        msaf_aux_e  aux_sel;
    } msaf_conv_req_s;

endpackage

// ===== tb/msaf_monitor_chk.sv
`timescale 1ns/100ps
module msaf_monitor_chk (
    // watched ports
    input wire logic                                                     clk_sys_i,
    input wire logic                                                     reset_i,
    input wire logic [7:0]                                               reg_addr_i,
    input wire logic                                                     reg_wr_i,
    input wire logic                                                     reg_rd_i,
    input wire logic [7:0]                                               reg_rdata_o,
    input wire logic                                                     vendor_mode_i,
    input msaf_pkg::msaf_conv_req_s                                      conv_req_o,
    input wire logic                                                     conv_done_i,
    input wire logic [msaf_pkg::RES_BITS-1:0]                            conv_result_i,
    input wire logic [msaf_pkg::CHAN_COUNT-1:0][msaf_pkg::RES_BITS-1:0] results_o,
    input wire logic                                                     scan_done_o,
    input wire logic                                                     irq_o,
    input wire logic                                                     transmit_fault_out_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    start_pulse_a: assert property (conv_req_o.start |=> !conv_req_o.start)
        else $error("start wider than one cycle");
    chan_order_a: assert property (!$past(reset_i) && $changed(conv_req_o.channel) |->
        conv_req_o.channel == (($past(conv_req_o.channel) == msaf_pkg::CH_RX) ?
        msaf_pkg::CH_TEMP : $past(conv_req_o.channel) + 3'h1)) else $error("channel out of order");
    restart_a: assert property (conv_done_i |-> ##2 conv_req_o.start)
        else $error("no start two cycles after done");
    scan_end_a: assert property (conv_done_i &&
        conv_req_o.channel == msaf_pkg::CH_RX |=> scan_done_o) else $error("scan done missing");
    scan_only_a: assert property (scan_done_o |-> $past(conv_done_i) &&
        $past(conv_req_o.channel) == msaf_pkg::CH_RX) else $error("stray scan done");
    temp_width_a: assert property (conv_done_i &&
        conv_req_o.channel == msaf_pkg::CH_TEMP |=>
        results_o[0] == ($past(conv_result_i) & 12'h1ff)) else $error("temperature result");
    bias_width_a: assert property (conv_done_i &&
        conv_req_o.channel == msaf_pkg::CH_BIAS |=>
        results_o[3] == ($past(conv_result_i) & 12'h0ff)) else $error("bias result");
    aux_lock_a: assert property (!vendor_mode_i [*3] |=>
        conv_req_o.aux_sel == msaf_pkg::AUX_SUPPLY) else $error("aux select outside vendor mode");
    irq_cause_a: assert property ($rose(irq_o) |->
        $past(conv_done_i, 2) || $past(reg_wr_i, 2)) else $error("interrupt without cause");
    fault_sub_a: assert property (transmit_fault_out_o |-> irq_o)
        else $error("fault from masked source");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    mask_b_a: assert property (reg_rd_i &&
        (reg_addr_i == msaf_pkg::ADDR_ALARM_MASK_B || reg_addr_i == msaf_pkg::ADDR_WARN_MASK_B)
        |=> reg_rdata_o[5:0] == 6'h00) else $error("reserved mask bits read");
endmodule // msaf_monitor_chk

bind msaf_monitor msaf_monitor_chk msaf_monitor_chk_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .vendor_mode_i(vendor_mode_i),
    .conv_req_o(conv_req_o), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .results_o(results_o), .scan_done_o(scan_done_o), .irq_o(irq_o),
    .transmit_fault_out_o(transmit_fault_out_o)
);

// ===== tb/msaf_conv_model.sv
`timescale 1ns/100ps
module msaf_conv_model (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    // converter side of the monitor
    input  msaf_pkg::msaf_conv_req_s conv_req_i,
    input  wire logic               slow_i,
    input  wire logic [4:0][11:0]   values_i,
    output logic                    conv_done_o,
    output logic      [11:0]        conv_result_o
);
    logic       busy_ff;
    logic [3:0] cnt_ff;

    // answers each start after a short or long delay; result bus toggles when idle
    always_ff @(posedge clk_sys_i) begin
        conv_done_o <= 1'b0;
        conv_result_o <= ~conv_result_o;
        if (reset_i) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            conv_result_o <= 12'h000;
        end else if (conv_req_i.start) begin
            busy_ff <= 1'b1;
            cnt_ff <= slow_i ? 4'h9 : 4'h0;
        end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
            conv_done_o <= 1'b1;
            conv_result_o <= values_i[conv_req_i.channel];
        end
    end
endmodule // msaf_conv_model

// ===== tb/test_msaf_monitor.sv
`timescale 1ns/100ps
module test_msaf_monitor;
    logic clk_sys_i, reset_i, reg_wr_i, reg_rd_i, vendor_mode_i, conv_done_i;
    logic transmit_off_input_i, scan_done_o, irq_o, transmit_fault_out_o, slow;
    logic [7:0]                   reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [11:0]                  conv_result_i;
    logic [4:0][11:0]             results_o, values;
    msaf_pkg::msaf_conv_req_s     conv_req_o;
    msaf_pkg::msaf_limits_s [4:0] limits_i;
    int                           errors, check_count;

    msaf_monitor msaf_monitor_inst (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .vendor_mode_i(vendor_mode_i), .conv_req_o(conv_req_o),
        .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .limits_i(limits_i),
        .transmit_off_input_i(transmit_off_input_i), .results_o(results_o),
        .scan_done_o(scan_done_o), .irq_o(irq_o), .transmit_fault_out_o(transmit_fault_out_o));
    msaf_conv_model msaf_conv_model_inst (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .conv_req_i(conv_req_o), .slow_i(slow),
        .values_i(values), .conv_done_o(conv_done_i), .conv_result_o(conv_result_i));

    // compare and report
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // register strobes, one cycle each, entered and left at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        @(negedge clk_sys_i);
        chk(12'(reg_rdata_o), 12'(exp));
    endtask
    // waits for n scan ends, bounded
    task automatic scan(input int n);
        int k;
        repeat (n) begin
            k = 0;
            while (scan_done_o !== 1'b1 && k < 400) begin
                @(negedge clk_sys_i);
                k++;
            end
            if (k >= 400) begin
                errors++;
                tally_and_finish();
            end
            @(negedge clk_sys_i);
        end
    endtask
    task automatic temp_hot(input logic on);
        values[0] = on ? 12'h1f8 : 12'h050;
        scan(2);
    endtask

    task automatic t_regs();
        rd(msaf_pkg::ADDR_ALARM_MASK_A, 8'h00);
        rd(msaf_pkg::ADDR_ALARM_MASK_B, 8'h40);
        rd(msaf_pkg::ADDR_WARN_MASK_A, 8'h00);
        rd(msaf_pkg::ADDR_WARN_MASK_B, 8'h40);
        rd(msaf_pkg::ADDR_CFG_FOUR, 8'h00);
        rd(8'h30, 8'h00);
        wr(msaf_pkg::ADDR_WARN_MASK_B, 8'hff);
        rd(msaf_pkg::ADDR_WARN_MASK_B, 8'hc0);
        wr(msaf_pkg::ADDR_WARN_MASK_B, 8'h40);
    endtask
    task automatic t_scan();
        slow = 1'b1;
        values = {12'hfff, 12'h3e7, 12'h2c3, 12'hfa5, 12'he1a};
        scan(2);
        chk(results_o[0], 12'h01a);
        chk(results_o[1], 12'h0a5);
        chk(results_o[2], 12'h0c3);
        chk(results_o[3], 12'h0e7);
        chk(results_o[4], 12'hfff);
        slow = 1'b0;
        values = {12'hfff, 12'h080, 12'h080, 12'h080, 12'h050};
        scan(2);
    endtask
    task automatic t_aux();
        vendor_mode_i = 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(msaf_pkg::ADDR_CFG_ZERO, 8'(c));
            chk(12'(conv_req_o.aux_sel), (c == 7) ? 12'h0 : 12'(c));
        end
        wr(msaf_pkg::ADDR_CFG_ZERO, 8'h05);
        vendor_mode_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(12'(conv_req_o.aux_sel), 12'h0);
    endtask
    task automatic t_latch();
        temp_hot(1'b1);
        chk(12'(irq_o), 12'h1);
        temp_hot(1'b0);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h80);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h00);
        rd(msaf_pkg::ADDR_WARN_STAT_A, 8'h80);
        chk(12'(irq_o), 12'h0);
        temp_hot(1'b1);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h80);
        scan(2);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h80);
        temp_hot(1'b0);
        transmit_off_input_i = ~transmit_off_input_i;
        repeat (8) @(negedge clk_sys_i);
        rd(msaf_pkg::ADDR_WARN_STAT_A, 8'h00);
    endtask
    task automatic t_rxlo();
        values[4] = 12'h000;
        limits_i[4].alarm_lo = 12'h010;
        scan(2);
        chk(12'(irq_o), 12'h0);
        values[4] = 12'hfff;
        limits_i[4].alarm_lo = 12'h000;
        scan(2);
        rd(msaf_pkg::ADDR_ALARM_STAT_B, 8'h40);
        rd(msaf_pkg::ADDR_WARN_STAT_B, 8'h00);
    endtask
    task automatic t_mask();
        temp_hot(1'b1);
        chk(12'(transmit_fault_out_o), 12'h0);
        wr(msaf_pkg::ADDR_CFG_FOUR, 8'h40);
        chk(12'(transmit_fault_out_o), 12'h1);
        wr(msaf_pkg::ADDR_ALARM_MASK_A, 8'h80);
        chk(12'(transmit_fault_out_o), 12'h0);
        chk(12'(irq_o), 12'h1);
        wr(msaf_pkg::ADDR_CFG_FOUR, 8'h80);
        chk(12'(transmit_fault_out_o), 12'h1);
        wr(msaf_pkg::ADDR_WARN_MASK_A, 8'h80);
        chk(12'(irq_o), 12'h0);
        chk(12'(transmit_fault_out_o), 12'h0);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h80);
        rd(msaf_pkg::ADDR_WARN_STAT_A, 8'h80);
        wr(msaf_pkg::ADDR_ALARM_MASK_A, 8'h00);
        wr(msaf_pkg::ADDR_WARN_MASK_A, 8'h00);
    endtask
    task automatic t_follow();
        wr(msaf_pkg::ADDR_CFG_FOUR, 8'h30);
        temp_hot(1'b1);
        temp_hot(1'b0);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h00);
        rd(msaf_pkg::ADDR_WARN_STAT_A, 8'h00);
        temp_hot(1'b1);
        rd(msaf_pkg::ADDR_ALARM_STAT_A, 8'h80);
    endtask

    // free-running clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // reset then the scenarios
    initial begin
        errors = 0;
        check_count = 0;
        {reset_i, reg_wr_i, reg_rd_i, vendor_mode_i} = 4'h8;
        {transmit_off_input_i, slow, reg_addr_i, reg_wdata_i} = 18'h0;
        values = {12'hfff, 12'h080, 12'h080, 12'h080, 12'h050};
        for (int i = 0; i < 5; i++)
            limits_i[i] = {12'hfff, 12'h000, 12'hfff, 12'h000};
        limits_i[0].alarm_hi = 12'h1f0;
        limits_i[0].warn_hi = 12'h1f0;
        repeat (20) @(negedge clk_sys_i);
        reset_i = 1'b0;
        t_regs();
        t_scan();
        t_aux();
        t_latch();
        t_rxlo();
        t_mask();
        t_follow();
        tally_and_finish();
    end
endmodule // test_msaf_monitor
